/* File: general_purpose_pin_port.sv */
// seven-pin general purpose port with peripheral arbitration and pull control
//
// Functional notes
// - five-bit first port, two-bit second port
// - second port tristated while receiver enabled
// - enabled shared peripheral overrides gpio function
// - shared functions disabled after reset
// - reset clears directions and pull enables
// - direction enables output and selects read
// - input buffer on unless analog function
// - digital function owns output buffer
// - analog function disables both buffers
// - input with buffer off reads zero
// - analog beats digital when both enabled
// - each pin except first port bit four has its own pullup
// - pullup off whenever pin is output
// - pullup off under analog control
// - key wake rising edge selects pulldown
// - inputs read level, outputs read latch
// - reset clears first port data register
// - first port bit four direction written like the rest, left to software
`include "gpio_port_map.svh"

module general_purpose_pin_port
  import gpio_port_pkg::*;
#(
  parameter int A_W = `FIRST_PORT_WIDTH,
  parameter int B_W = `SECOND_PORT_WIDTH,
  parameter int K_W = `KEY_WAKE_WIDTH
) (
  // clock and reset
  input  wire logic           clk,
  input  wire logic           nrst,
  // software write strobes and data
  input  wire logic           first_data_wr,
  input  wire logic [A_W-1:0] first_data_wdata,
  input  wire logic           first_dir_wr,
  input  wire logic [A_W-1:0] first_dir_wdata,
  input  wire logic           first_pull_wr,
  input  wire logic [K_W-1:0] first_pull_wdata,
  input  wire logic           second_data_wr,
  input  wire logic [B_W-1:0] second_data_wdata,
  input  wire logic           second_dir_wr,
  input  wire logic [B_W-1:0] second_dir_wdata,
  input  wire logic           second_pull_wr,
  input  wire logic [B_W-1:0] second_pull_wdata,
  // register read back
  output logic      [A_W-1:0] first_port_data_reg,
  output logic      [A_W-1:0] first_port_directions,
  output logic      [K_W-1:0] first_port_pull_enables,
  output logic      [B_W-1:0] second_port_data_reg,
  output logic      [B_W-1:0] second_port_directions,
  output logic      [B_W-1:0] second_port_pull_enables,
  // shared peripheral requests on first port
  input  wire logic [A_W-1:0] periph_digital_en,
  input  wire logic [A_W-1:0] periph_digital_oe,
  input  wire logic [A_W-1:0] periph_digital_out,
  input  wire logic [A_W-1:0] periph_analog_en,
  output logic      [A_W-1:0] periph_digital_in,
  // key wake and receiver controls
  input  wire logic [K_W-1:0] key_wake_pin_enable,
  input  wire logic [K_W-1:0] key_wake_edge_select,
  input  wire logic           low_freq_receiver,
  // pins: output enable is active low
  input  wire logic [A_W-1:0] first_port_pins_in,
  output logic      [A_W-1:0] first_port_pins_out,
  output logic      [A_W-1:0] first_port_pins_oe_n,
  output logic      [A_W-1:0] first_port_pullup,
  output logic      [K_W-1:0] first_port_pulldown,
  output logic      [A_W-1:0] first_port_ibuf_en,
  input  wire logic [B_W-1:0] second_port_pins_in,
  output logic      [B_W-1:0] second_port_pins_out,
  output logic      [B_W-1:0] second_port_pins_oe_n,
  output logic      [B_W-1:0] second_port_pullup
);

  logic [A_W-1:0] a_data_ff;
  logic [A_W-1:0] nxt_a_data;
  logic [A_W-1:0] a_dir_ff;
  logic [A_W-1:0] nxt_a_dir;
  logic [K_W-1:0] a_pull_ff;
  logic [K_W-1:0] nxt_a_pull;
  logic [B_W-1:0] b_data_ff;
  logic [B_W-1:0] nxt_b_data;
  logic [B_W-1:0] b_dir_ff;
  logic [B_W-1:0] nxt_b_dir;
  logic [B_W-1:0] b_pull_ff;
  logic [B_W-1:0] nxt_b_pull;

  // pin synchronisers; stage one feeds stage two only
  logic [A_W-1:0] a_meta_ff;
  logic [A_W-1:0] a_sync_ff;
  logic [B_W-1:0] b_meta_ff;
  logic [B_W-1:0] b_sync_ff;

  // read values are registered so data outputs come from flip-flops
  logic [A_W-1:0] a_rd_ff;
  logic [A_W-1:0] nxt_a_rd;
  logic [B_W-1:0] b_rd_ff;
  logic [B_W-1:0] nxt_b_rd;

  // per-pin arbitration results
  pin_owner_t     owner [A_W];
  logic [A_W-1:0] a_out_en;
  logic [A_W-1:0] a_pins_out;
  logic [A_W-1:0] a_ibuf;
  logic [A_W-1:0] a_no_pull;

  // second port release and pull gating
  logic [B_W-1:0] b_live;
  logic [B_W-1:0] b_no_pull;
  logic [B_W-1:0] b_pull_on;

  // analog wins over digital, digital over gpio
  function automatic pin_owner_t pick_owner(input logic dig, input logic ana);
    pick_owner = ana ? pin_analog : (dig ? pin_digital : pin_gpio);
  endfunction : pick_owner

  // a pull only acts on a pin that nothing drives or claims for analog use
  function automatic logic pull_gate(input logic en, input logic blocked);
    pull_gate = en & ~blocked;
  endfunction : pull_gate

  // first port register writes
  always_comb begin
    nxt_a_data = a_data_ff;
    nxt_a_dir  = a_dir_ff;
    nxt_a_pull = a_pull_ff;
    // writes latch into every data bit
    if (first_data_wr) begin
      nxt_a_data = first_data_wdata;
    end
    // bit four written like the rest; keeping it an output is software's job
    if (first_dir_wr) begin
      nxt_a_dir = first_dir_wdata;
    end
    if (first_pull_wr) begin
      nxt_a_pull = first_pull_wdata;
    end
  end

  // second port register writes
  always_comb begin
    nxt_b_data = b_data_ff;
    nxt_b_dir  = b_dir_ff;
    nxt_b_pull = b_pull_ff;
    if (second_data_wr) begin
      nxt_b_data = second_data_wdata;
    end
    if (second_dir_wr) begin
      nxt_b_dir = second_dir_wdata;
    end
    if (second_pull_wr) begin
      nxt_b_pull = second_pull_wdata;
    end
  end

  always_ff @(posedge clk) begin
    // directions and pulls clear on reset
    if (!nrst) begin
      a_data_ff <= `FIRST_DATA_RST;
      a_dir_ff  <= `FIRST_DIR_RST;
      a_pull_ff <= `FIRST_PULL_RST;
    end else begin
      a_data_ff <= nxt_a_data;
      a_dir_ff  <= nxt_a_dir;
      a_pull_ff <= nxt_a_pull;
    end
  end

  always_ff @(posedge clk) begin
    // second port directions and pulls clear too
    if (!nrst) begin
      b_data_ff <= `SECOND_DATA_RST;
      b_dir_ff  <= `SECOND_DIR_RST;
      b_pull_ff <= `SECOND_PULL_RST;
    end else begin
      b_data_ff <= nxt_b_data;
      b_dir_ff  <= nxt_b_dir;
      b_pull_ff <= nxt_b_pull;
    end
  end

  // pins are asynchronous; no reset so the chain only ever samples the pad
  always_ff @(posedge clk) begin
    a_meta_ff <= first_port_pins_in;
    a_sync_ff <= a_meta_ff;
  end

  always_ff @(posedge clk) begin
    b_meta_ff <= second_port_pins_in;
    b_sync_ff <= b_meta_ff;
  end

  // first port per-pin arbitration
  always_comb begin
    for (int i = 0; i < A_W; i++) begin
      owner[i] = pick_owner(periph_digital_en[i], periph_analog_en[i]);
      case (owner[i])
        // direction bit drives the output buffer
        pin_gpio: begin
          a_out_en[i]   = a_dir_ff[i];
          a_pins_out[i] = a_data_ff[i];
          a_ibuf[i]     = 1'b1;
        end
        // digital function owns the output buffer
        pin_digital: begin
          a_out_en[i]   = periph_digital_oe[i];
          a_pins_out[i] = periph_digital_out[i];
          a_ibuf[i]     = 1'b1;
        end
        pin_analog: begin
          a_out_en[i]   = 1'b0;
          a_pins_out[i] = 1'b0;
          a_ibuf[i]     = 1'b0;
        end
        default: begin
          a_out_en[i]   = 1'b0;
          a_pins_out[i] = 1'b0;
          a_ibuf[i]     = 1'b0;
        end
      endcase
      // no pullup on any driven pin
      a_no_pull[i] = a_out_en[i] | (owner[i] == pin_analog);
    end
  end

  // first port read path
  always_comb begin
    for (int i = 0; i < A_W; i++) begin
      // input with buffer off reads zero
      nxt_a_rd[i] = a_dir_ff[i] ? a_data_ff[i] : (a_ibuf[i] & a_sync_ff[i]);
    end
  end

  // pull resistors on the key wake pins
  genvar k;
  generate
    for (k = 0; k < K_W; k++) begin : g_pull
      // rising-edge key wake swaps to pulldown
      assign first_port_pullup[k]   = pull_gate(a_pull_ff[k], a_no_pull[k])
                                      & ~(key_wake_pin_enable[k] & key_wake_edge_select[k]);
      assign first_port_pulldown[k] = pull_gate(a_pull_ff[k], a_no_pull[k])
                                      & key_wake_pin_enable[k] & key_wake_edge_select[k];
    end
    // pins above the pull field have none
    for (k = K_W; k < A_W; k++) begin : g_nopull
      assign first_port_pullup[k] = 1'b0;
    end
  endgenerate

  // second port: gpio only, receiver tristates it
  always_comb begin
    for (int j = 0; j < B_W; j++) begin
      nxt_b_rd[j] = b_dir_ff[j] ? b_data_ff[j] : (b_sync_ff[j] & b_live[j]);
      // no pullup while driving or released
      b_pull_on[j] = pull_gate(b_pull_ff[j], b_no_pull[j]);
    end
  end

  // one register stage on reads keeps the data outputs glitch free
  always_ff @(posedge clk) begin
    if (!nrst) begin
      a_rd_ff <= `FIRST_DATA_RST;
      b_rd_ff <= `SECOND_DATA_RST;
    end else begin
      a_rd_ff <= nxt_a_rd;
      b_rd_ff <= nxt_b_rd;
    end
  end

  // peripheral enables come from their modules, low out of reset
  assign periph_digital_in       = a_sync_ff & a_ibuf;
  assign first_port_pins_out     = a_pins_out;
  assign first_port_pins_oe_n    = ~a_out_en;
  assign first_port_ibuf_en      = a_ibuf;
  assign first_port_data_reg     = a_rd_ff;
  assign first_port_directions   = a_dir_ff;
  assign first_port_pull_enables = a_pull_ff;

  // receiver enable floats the second port
  assign b_live                   = {B_W{~low_freq_receiver}};
  assign b_no_pull                = b_dir_ff | ~b_live;
  assign second_port_pins_oe_n    = ~(b_dir_ff & b_live);
  assign second_port_pins_out     = b_data_ff;
  assign second_port_pullup       = b_pull_on;
  assign second_port_data_reg     = b_rd_ff;
  assign second_port_directions   = b_dir_ff;
  assign second_port_pull_enables = b_pull_ff;

endmodule : general_purpose_pin_port

/* File: gpio_port_map.svh */
// offsets, widths and reset values of the general purpose pin port
`ifndef GPIO_PORT_MAP_SVH
`define GPIO_PORT_MAP_SVH
`define FIRST_PORT_WIDTH     5
`define SECOND_PORT_WIDTH    2
`define KEY_WAKE_WIDTH       4
`define FIRST_PORT_OFS       2'h0
`define FIRST_PULL_OFS       2'h1
`define FIRST_DIR_OFS        2'h3
`define SECOND_PORT_OFS      2'h2
`define FIRST_DATA_RST       5'h00
`define FIRST_DIR_RST        5'h00
`define FIRST_PULL_RST       4'h0
`define SECOND_DATA_RST      2'h0
`define SECOND_DIR_RST       2'h0
`define SECOND_PULL_RST      2'h0
`define OUTPUT_ONLY_BIT      4
`endif

/* File: gpio_port_pkg.sv */
// types shared by the general purpose pin port
package gpio_port_pkg;
  typedef enum logic [2:0] {
    pin_gpio    = 3'h1,
    pin_digital = 3'h2,
    pin_analog  = 3'h4
  } pin_owner_t;
endpackage : gpio_port_pkg

/* File: gpio_board.sv */
// board model: pin levels from device drive, pulls and outside drivers
module gpio_board (
  // clock
  input  wire logic       clk,
  // first port
  input  wire logic [4:0] first_port_pins_out, first_port_pins_oe_n,
  input  wire logic [4:0] first_port_pullup, a_drv, a_ext,
  input  wire logic [3:0] first_port_pulldown,
  output logic      [4:0] first_port_pins_in,
  // second port
  input  wire logic [1:0] second_port_pins_out, second_port_pins_oe_n,
  input  wire logic [1:0] second_port_pullup, b_drv, b_ext,
  output logic      [1:0] second_port_pins_in
);
  logic       tg = 1'b0;
  logic [4:0] idle;
  // a floating line wanders every cycle so a stale value never passes
  always @(posedge clk) tg <= ~tg;
  assign idle = a_drv & a_ext | ~a_drv & (first_port_pullup | ~{1'b0, first_port_pulldown} & {5{tg}});
  assign first_port_pins_in = ~first_port_pins_oe_n & first_port_pins_out | first_port_pins_oe_n & idle;
  assign second_port_pins_in = ~second_port_pins_oe_n & second_port_pins_out
    | second_port_pins_oe_n & (b_drv & b_ext | ~b_drv & (second_port_pullup | {2{tg}}));
endmodule : gpio_board

/* File: general_purpose_pin_port_chk.sv */
// concurrent checks on the general purpose pin port
module gpio_port_chk (
  input wire logic       clk, nrst, first_dir_wr, low_freq_receiver,
  input wire logic [4:0] first_dir_wdata, first_port_directions, periph_digital_en,
  input wire logic [4:0] periph_digital_oe, periph_analog_en, first_port_pins_oe_n,
  input wire logic [4:0] first_port_pullup, first_port_ibuf_en,
  input wire logic [3:0] first_port_pull_enables, key_wake_pin_enable, key_wake_edge_select,
  input wire logic [3:0] first_port_pulldown,
  input wire logic [1:0] second_port_pins_oe_n, second_port_pullup
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence dir_taken; first_dir_wr; endsequence
  reset_clear_a: assert property ($rose(nrst) |-> first_port_directions == 5'h00
    && first_port_pull_enables == 4'h0) else $error("config not cleared by reset");
  dir_store_a: assert property (dir_taken |=> first_port_directions == $past(first_dir_wdata))
    else $error("direction write lost");
  gpio_oe_a: assert property (((first_port_pins_oe_n ^ ~first_port_directions)
    & ~(periph_digital_en | periph_analog_en)) == 5'h00) else $error("gpio drive wrong");
  digital_oe_a: assert property (((first_port_pins_oe_n ^ ~periph_digital_oe)
    & periph_digital_en & ~periph_analog_en) == 5'h00) else $error("peripheral drive wrong");
  ibuf_on_a: assert property (first_port_ibuf_en == ~periph_analog_en)
    else $error("input buffer wrong");
  analog_off_a: assert property ((~first_port_pins_oe_n & periph_analog_en) == 5'h00)
    else $error("analog pin driven");
  pull_off_a: assert property ((first_port_pullup
    & (~first_port_pins_oe_n | periph_analog_en)) == 5'h00) else $error("pullup not forced off");
  pulldown_sel_a: assert property ((first_port_pulldown & first_port_pullup[3:0]) == 4'h0
    && (first_port_pulldown & ~(key_wake_pin_enable & key_wake_edge_select)) == 4'h0)
    else $error("pulldown choice wrong");
  recv_hiz_a: assert property (low_freq_receiver |-> second_port_pins_oe_n == 2'h3
    && second_port_pullup == 2'h0) else $error("second port not released");
endmodule : gpio_port_chk
bind general_purpose_pin_port gpio_port_chk i_chk (.*);

/* File: general_purpose_pin_port_test.sv */
// self-checking bench for the general purpose pin port
module general_purpose_pin_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, nrst = 1'b0, low_freq_receiver, first_data_wr, first_dir_wr, first_pull_wr;
  logic second_data_wr, second_dir_wr, second_pull_wr;
  logic [4:0] first_data_wdata, first_dir_wdata, periph_digital_en, periph_digital_oe, a_drv, a_ext;
  logic [4:0] periph_digital_out, periph_analog_en, first_port_pins_in, first_port_data_reg;
  logic [4:0] first_port_directions, periph_digital_in, first_port_pins_out, first_port_pins_oe_n;
  logic [4:0] first_port_pullup, first_port_ibuf_en;
  logic [3:0] first_pull_wdata, first_port_pull_enables, key_wake_pin_enable;
  logic [3:0] key_wake_edge_select, first_port_pulldown;
  logic [1:0] second_data_wdata, second_dir_wdata, second_pull_wdata, second_port_data_reg, b_drv;
  logic [1:0] second_port_directions, second_port_pull_enables, second_port_pins_in, b_ext;
  logic [1:0] second_port_pins_out, second_port_pins_oe_n, second_port_pullup;
  int         fail_count = 0, n_tests = 0;
  general_purpose_pin_port i_dut (.*);
  gpio_board i_brd (.*);
  always #25 clk = ~clk;
  task automatic chk(input logic [15:0] s, e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic test_done;
    $display("%0d checks, %0d mismatches", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  task automatic cfg_a(input logic [4:0] d, r, input logic [3:0] p);
    {first_data_wr, first_pull_wr, first_data_wdata, first_pull_wdata} = {2'h3, d, p};
    tick(1);
    {first_data_wr, first_pull_wr, first_dir_wr, first_dir_wdata} = {3'h1, r};
    tick(1);
    first_dir_wr = 1'b0;
    tick(4);
  endtask : cfg_a
  task automatic cfg_b(input logic [1:0] d, r, p);
    {second_data_wr, second_pull_wr, second_data_wdata, second_pull_wdata} = {2'h3, d, p};
    tick(1);
    {second_data_wr, second_pull_wr, second_dir_wr, second_dir_wdata} = {3'h1, r};
    tick(1);
    second_dir_wr = 1'b0;
    tick(4);
  endtask : cfg_b
  initial begin
    #50us;
    fail_count++;
    test_done();
  end
  initial begin
    {first_data_wr, first_dir_wr, first_pull_wr, second_data_wr, second_dir_wr} = 5'h00;
    {second_pull_wr, first_data_wdata, first_dir_wdata, first_pull_wdata} = 15'h0000;
    {second_data_wdata, second_dir_wdata, second_pull_wdata, low_freq_receiver} = 7'h00;
    {periph_digital_en, periph_digital_oe, periph_digital_out, periph_analog_en} = 20'h00000;
    {key_wake_pin_enable, key_wake_edge_select, a_drv, a_ext, b_drv, b_ext} = 22'h003ff0;
    tick(20);
    chk(first_port_data_reg, 8'h00);
    nrst = 1'b1;
    tick(4);
    chk({first_port_directions, first_port_pull_enables}, 8'h00);
    chk({second_port_directions, second_port_pull_enables}, 8'h00);
    chk({first_port_pins_oe_n, second_port_pins_oe_n}, 8'h7f);
    chk({first_port_pullup, second_port_pullup}, 8'h00);
    chk(first_port_ibuf_en, 8'h1f);
    chk(first_port_data_reg, 8'h1f);
    $display("reset test done");
    a_ext = 5'h0a;
    cfg_a(5'h15, 5'h1f, 4'hf);
    chk(first_port_pins_oe_n, 8'h00);
    chk(first_port_pins_out, 8'h15);
    chk(first_port_data_reg, 8'h15);
    chk(first_port_pullup, 8'h00);
    {a_drv, a_ext} = 10'h210;
    cfg_a(5'h00, 5'h00, 4'hf);
    chk(first_port_pullup, 8'h0f);
    chk(first_port_data_reg, 8'h1f);
    {key_wake_pin_enable, key_wake_edge_select} = 8'hf5;
    tick(4);
    chk({first_port_pullup, first_port_pulldown}, 12'h0a5);
    chk(first_port_data_reg, 8'h1a);
    $display("pull test done");
    {key_wake_pin_enable, a_drv, a_ext} = 14'h0252;
    cfg_a(5'h00, 5'h02, 4'hf);
    {periph_digital_en, periph_digital_oe, periph_digital_out} = 15'h0c21;
    tick(4);
    chk(first_port_pins_oe_n, 8'h1e);
    chk(first_port_pins_out[0], 8'h01);
    chk(first_port_pullup & 5'h0d, 8'h0c);
    chk(first_port_data_reg, 8'h1d);
    chk(periph_digital_in & 5'h03, 8'h03);
    periph_analog_en = 5'h03;
    tick(4);
    chk(first_port_ibuf_en, 8'h1c);
    chk(first_port_pins_oe_n & 5'h03, 8'h03);
    chk(first_port_pullup & 5'h03, 8'h00);
    chk(first_port_data_reg, 8'h1c);
    $display("peripheral test done");
    {b_drv, b_ext} = 4'h0;
    cfg_b(2'h2, 2'h3, 2'h3);
    chk({second_port_pins_oe_n, second_port_pins_out, second_port_pullup}, 8'h08);
    chk(second_port_data_reg, 8'h02);
    low_freq_receiver = 1'b1;
    tick(4);
    chk(second_port_pins_oe_n, 8'h03);
    low_freq_receiver = 1'b0;
    cfg_b(2'h2, 2'h0, 2'h3);
    chk({second_port_pullup, second_port_data_reg}, 8'h0f);
    low_freq_receiver = 1'b1;
    tick(4);
    chk({second_port_pins_oe_n, second_port_pullup, second_port_data_reg}, 8'h30);
    $display("second port test done");
    test_done();
  end
endmodule : general_purpose_pin_port_test
